// ### arr_reply_receiver.sv
`timescale 1ns/1ns
// Summary of operation
// (RQ1) antenna replies ten bits within 100 ms
// (RQ2) no full reply in 100 ms sets timeout
// (RQ3) host arms receive: direction clear, auto set
// (RQ4) receive done sets status bit, may interrupt
// (RQ5) ten-bit reply readable at 62h/63h
// (RQ6) badly received reply sets error flag
// (RQ7) nonzero, no error: advanced antenna data
// (RQ8) zero, no error: basic antenna assumed
// (RQ9) all general pins inputs after power-up
// (RQ10) alternate functions for pins 0,5,6,7; code uses pins 0,1,5,7, pin 6 is reserved
// (RQ11) async low reset, release synchronised
// (RQ12) controller holds reset low one microsecond
// (RQ13) host waits 200 us before bus traffic
// (RQ14) outputs stay undriven through power-up
// (RQ15) direction pin high transmitting, low receiving
// (RQ16) started but incomplete reply sets timeout
// (RQ17) timeout counted from transmit end onward
module arr_reply_receiver
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary
   parameter int         TMO_CYC  = arr_pkg::REPLY_TMO_CYC,
   parameter int         GAP_CYC  = arr_pkg::BIT_GAP_CYC
)
(
   // clock and resets
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        reset_in_n,
   // host serial bus
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_oe,
   // transmit path
   input  wire logic        tx_busy,
   input  wire logic        tx_done,
   input  wire logic        tx_line_level,
   input  wire logic        sync_in,
   // antenna line
   input  wire logic        antenna_line_pin_in,
   output logic             antenna_line_pin_out,
   output logic             antenna_line_pin_oe,
   // general pins
   input  wire logic [7:0]  gpio_in,
   output logic [7:0]       gpio_out,
   output logic [7:0]       gpio_oe
);

   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WREG, I_WDAT, I_ACK, I_RDAT, I_RACK}
      arr_i2c_e;

   // reset pin: assert at once, release on the clock
   logic [1:0] por_r;
   logic       rst;
   always_ff @(posedge mclk or negedge reset_in_n)
   begin
      if (!reset_in_n)
         por_r <= 2'h3;
      else
         por_r <= {por_r[0], 1'b0}; // RQ11
   end
   assign rst = sys_rst | por_r[1];

   // registers
   logic [7:0]                     func_r, func_nxt;
   logic [7:0]                     ctl_r, ctl_nxt;
   logic [7:0]                     stat_r, stat_nxt;
   logic [7:0]                     mask_r, mask_nxt;
   logic [arr_pkg::REPLY_BITS-1:0] data_r, data_nxt;
   arr_pkg::arr_wr_s               wr;
   arr_pkg::arr_result_s           res;
   logic                           rx_start;
   logic                           rx_busy;
   logic                           rx_line;

   function automatic logic [7:0] read_reg(input logic [7:0] a);
      case (a)
         arr_pkg::OFS_GPIO_FUNC:  read_reg = func_r;
         arr_pkg::OFS_LINK_CTRL:  read_reg = ctl_r;
         arr_pkg::OFS_REPLY_LO:   read_reg = data_r[7:0]; // RQ5
         arr_pkg::OFS_REPLY_HI:   read_reg = {6'h00, data_r[9:8]};
         arr_pkg::OFS_IRQ_STATUS: read_reg = stat_r;
         arr_pkg::OFS_IRQ_MASK:   read_reg = mask_r;
         default:                 read_reg = 8'h00;
      endcase
   endfunction : read_reg

   function automatic logic is_wr(input arr_pkg::arr_wr_s w, input logic [7:0] a);
      is_wr = w.en && (w.addr == a);
   endfunction : is_wr

   // arming write or end of transmit in auto mode
   assign rx_start = (is_wr(wr, arr_pkg::OFS_LINK_CTRL) && !wr.data[arr_pkg::CTL_DIR_SEL]
                      && wr.data[arr_pkg::CTL_AUTO_RX]) // RQ3
                     || (tx_done && ctl_r[arr_pkg::CTL_AUTO_RX]); // RQ17

   // one-pin mode shares the line; two-pin uses general pin 0
   always_comb
   begin
      if (ctl_r[arr_pkg::CTL_ONE_PIN])
         rx_line = tx_busy | antenna_line_pin_in;
      else if (func_r[arr_pkg::GP_ANT_IN])
         rx_line = gpio_in[arr_pkg::GP_ANT_IN]; // RQ10
      else
         rx_line = 1'b1;
   end

   arr_reply_decoder
   #(
      .TMO_CYC (TMO_CYC),
      .GAP_CYC (GAP_CYC),
      .ONE_CYC (arr_pkg::BIT_ONE_CYC)
   )
   u_dec
   (
      .mclk    (mclk),
      .rst     (rst),
      .start   (rx_start),
      .line_in (rx_line),
      .res     (res),
      .busy    (rx_busy)
   );

   always_comb
   begin
      func_nxt = func_r;
      ctl_nxt  = ctl_r;
      mask_nxt = mask_r;
      data_nxt = data_r;
      stat_nxt = stat_r;
      if (is_wr(wr, arr_pkg::OFS_GPIO_FUNC))
         func_nxt = wr.data; // RQ10
      if (is_wr(wr, arr_pkg::OFS_LINK_CTRL))
         ctl_nxt = (wr.data & arr_pkg::CTL_WR_MASK) | (ctl_r & ~arr_pkg::CTL_WR_MASK);
      if (is_wr(wr, arr_pkg::OFS_IRQ_MASK))
         mask_nxt = wr.data;
      if (is_wr(wr, arr_pkg::OFS_IRQ_CLEAR))
         stat_nxt = stat_r & ~wr.data;
      if (rx_start)
      begin
         // stale reply cleared so a silent antenna reads zero
         data_nxt = '0; // RQ8
         ctl_nxt[arr_pkg::CTL_RX_ERR] = 1'b0;
      end
      // hardware sets win over software clears
      if (res.done)
      begin
         data_nxt = res.data; // RQ5
         stat_nxt[arr_pkg::ST_RX_DONE] = 1'b1; // RQ4
      end
      if (res.timeout)
         stat_nxt[arr_pkg::ST_TIMEOUT] = 1'b1; // RQ2
      if (res.error)
         ctl_nxt[arr_pkg::CTL_RX_ERR] = 1'b1; // RQ6
      if (tx_done)
         stat_nxt[arr_pkg::ST_TX_DONE] = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         func_r <= arr_pkg::REG_RESET;
         ctl_r  <= arr_pkg::REG_RESET;
         stat_r <= arr_pkg::REG_RESET;
         mask_r <= arr_pkg::REG_RESET;
         data_r <= '0;
      end
      else
      begin
         func_r <= func_nxt;
         ctl_r  <= ctl_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         data_r <= data_nxt;
      end
   end

   // pins: general pins undriven until software selects a function or one-pin mode; antenna line driven while tx_busy and no receive runs
   logic [7:0] gout_r, gout_nxt, goe_r, goe_nxt;
   logic       lout_r, lout_nxt, loe_r, loe_nxt;
   always_comb
   begin
      gout_nxt = '0;
      goe_nxt  = '0; // RQ9
      gout_nxt[arr_pkg::GP_DIR]  = tx_busy; // RQ15
      goe_nxt[arr_pkg::GP_DIR]   = ctl_r[arr_pkg::CTL_ONE_PIN];
      gout_nxt[arr_pkg::GP_SYNC] = sync_in;
      goe_nxt[arr_pkg::GP_SYNC]  = func_r[arr_pkg::GP_SYNC]; // RQ10
      gout_nxt[arr_pkg::GP_IRQ]  = |(stat_r & mask_r); // RQ4
      goe_nxt[arr_pkg::GP_IRQ]   = func_r[arr_pkg::GP_IRQ]; // RQ10
      lout_nxt = tx_line_level;
      loe_nxt  = tx_busy && !rx_busy;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         gout_r <= '0;
         goe_r  <= '0; // RQ14
         lout_r <= 1'b0;
         loe_r  <= 1'b0; // RQ14
      end
      else
      begin
         gout_r <= gout_nxt;
         goe_r  <= goe_nxt;
         lout_r <= lout_nxt;
         loe_r  <= loe_nxt;
      end
   end

   assign gpio_out             = gout_r;
   assign gpio_oe              = goe_r;
   assign antenna_line_pin_out = lout_r;
   assign antenna_line_pin_oe  = loe_r;

   // host serial slave; pins sampled as synchronous levels
   arr_i2c_e         is_r, is_nxt, ret_r, ret_nxt;
   logic             scl_q, sda_q;
   logic [7:0]       sh_r, sh_nxt, ptr_r, ptr_nxt;
   logic [2:0]       cnt_r, cnt_nxt;
   logic             full_r, full_nxt, oe_r, oe_nxt;
   arr_pkg::arr_wr_s wr_r, wr_nxt;
   logic             scl_rise, scl_fall, bus_start, bus_stop;

   assign scl_rise  = scl_in && !scl_q;
   assign scl_fall  = !scl_in && scl_q;
   assign bus_start = scl_in && scl_q && sda_q && !sda_in;
   assign bus_stop  = scl_in && scl_q && !sda_q && sda_in;

   always_comb
   begin
      is_nxt   = is_r;
      ret_nxt  = ret_r;
      sh_nxt   = sh_r;
      ptr_nxt  = ptr_r;
      cnt_nxt  = cnt_r;
      full_nxt = full_r;
      oe_nxt   = oe_r;
      wr_nxt   = '0;
      if (bus_start)
      begin
         is_nxt   = I_ADDR;
         cnt_nxt  = '0;
         full_nxt = 1'b0;
         oe_nxt   = 1'b0;
      end
      else if (bus_stop)
      begin
         is_nxt = I_IDLE;
         oe_nxt = 1'b0;
      end
      else
         case (is_r)
            I_ADDR, I_WREG, I_WDAT:
               if (scl_rise && !full_r)
               begin
                  sh_nxt   = {sh_r[6:0], sda_in};
                  cnt_nxt  = cnt_r + 1'b1;
                  full_nxt = (cnt_r == 3'h7);
               end
               else if (scl_fall && full_r)
               begin
                  full_nxt = 1'b0;
                  is_nxt   = I_ACK;
                  oe_nxt   = 1'b1;
                  if (is_r == I_ADDR)
                  begin
                     ret_nxt = sh_r[0] ? I_RDAT : I_WREG;
                     if (sh_r[7:1] != DEV_ADDR)
                     begin
                        is_nxt = I_IDLE;
                        oe_nxt = 1'b0;
                     end
                  end
                  else if (is_r == I_WREG)
                  begin
                     ptr_nxt = sh_r;
                     ret_nxt = I_WDAT;
                  end
                  else
                  begin
                     wr_nxt  = '{en: 1'b1, addr: ptr_r, data: sh_r};
                     ptr_nxt = ptr_r + 1'b1;
                     ret_nxt = I_WDAT;
                  end
               end
            I_ACK, I_RACK:
               if (is_r == I_RACK && scl_rise)
                  full_nxt = !sda_in;
               else if (scl_fall)
               begin
                  oe_nxt = 1'b0;
                  is_nxt = (is_r == I_ACK) ? ret_r : I_IDLE;
                  if (is_nxt == I_RDAT || (is_r == I_RACK && full_r))
                  begin
                     // first data bit goes out on this falling edge
                     sh_nxt   = read_reg(ptr_r);
                     ptr_nxt  = ptr_r + 1'b1;
                     oe_nxt   = !sh_nxt[7];
                     is_nxt   = I_RDAT;
                     full_nxt = 1'b0;
                  end
                  cnt_nxt = '0;
               end
            I_RDAT:
               if (scl_fall)
               begin
                  cnt_nxt = cnt_r + 1'b1;
                  if (cnt_r == 3'h7)
                  begin
                     oe_nxt = 1'b0;
                     is_nxt = I_RACK;
                  end
                  else
                  begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_nxt = !sh_r[6];
                  end
               end
            default:
               is_nxt = I_IDLE;
         endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         is_r   <= I_IDLE;
         ret_r  <= I_IDLE;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         sh_r   <= '0;
         ptr_r  <= '0;
         cnt_r  <= '0;
         full_r <= 1'b0;
         oe_r   <= 1'b0; // RQ14
         wr_r   <= '0;
      end
      else
      begin
         is_r   <= is_nxt;
         ret_r  <= ret_nxt;
         scl_q  <= scl_in;
         sda_q  <= sda_in;
         sh_r   <= sh_nxt;
         ptr_r  <= ptr_nxt;
         cnt_r  <= cnt_nxt;
         full_r <= full_nxt;
         oe_r   <= oe_nxt;
         wr_r   <= wr_nxt;
      end
   end

   assign wr     = wr_r;
   assign sda_oe = oe_r;

endmodule : arr_reply_receiver

// ### arr_pkg.sv
package arr_pkg;

   // register offsets
   localparam logic [7:0] OFS_GPIO_FUNC  = 8'h4F;
   localparam logic [7:0] OFS_LINK_CTRL  = 8'h5F;
   localparam logic [7:0] OFS_REPLY_LO   = 8'h62;
   localparam logic [7:0] OFS_REPLY_HI   = 8'h63;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hFB;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'hFD;
   localparam logic [7:0] OFS_IRQ_CLEAR  = 8'hFF;
   localparam logic [7:0] REG_RESET      = 8'h00;

   // link control bit positions
   localparam int CTL_ONE_PIN = 0;
   localparam int CTL_DIR_SEL = 2;
   localparam int CTL_TX_GO   = 3;
   localparam int CTL_AUTO_RX = 4;
   localparam int CTL_RX_ERR  = 5;
   localparam logic [7:0] CTL_WR_MASK = 8'h15;

   // status bit positions
   localparam int ST_TIMEOUT = 3;
   localparam int ST_TX_DONE = 4;
   localparam int ST_RX_DONE = 5;

   // gpio alternate function bit positions
   localparam int GP_ANT_IN = 0;
   localparam int GP_DIR    = 1;
   localparam int GP_SYNC   = 5;
   localparam int GP_RSVD   = 6;
   localparam int GP_IRQ    = 7;
   localparam int GPIO_N    = 8;

   // reply format and timing
   localparam int REPLY_BITS   = 10;
   localparam int CLK_HZ       = 25_000_000;
   localparam int REPLY_TMO_MS = 100;
   localparam int REPLY_TMO_CYC = CLK_HZ / 1000 * REPLY_TMO_MS;
   localparam int BIT_ONE_US   = 100;
   localparam int BIT_ONE_CYC  = (CLK_HZ / 1_000_000) * BIT_ONE_US;
   localparam int BIT_GAP_US   = 2000;
   localparam int BIT_GAP_CYC  = (CLK_HZ / 1_000_000) * BIT_GAP_US;
   localparam int CNT_W        = 22;

   typedef struct packed {
      logic                  done;
      logic                  timeout;
      logic                  error;
      logic [REPLY_BITS-1:0] data;
   } arr_result_s;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } arr_wr_s;

endpackage : arr_pkg

// ### arr_reply_decoder.sv
`timescale 1ns/1ns
module arr_reply_decoder
#(
   parameter int TMO_CYC = arr_pkg::REPLY_TMO_CYC,
   parameter int GAP_CYC = arr_pkg::BIT_GAP_CYC,
   parameter int ONE_CYC = arr_pkg::BIT_ONE_CYC
)
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // control
   input  wire logic          start,
   input  wire logic          line_in,
   // result
   output arr_pkg::arr_result_s res,
   output logic               busy
);

   typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_LOW, RX_HIGH} arr_rx_e;

   localparam int CNT_W = arr_pkg::CNT_W;

   arr_rx_e                         st_r, st_nxt;
   logic [arr_pkg::CNT_W-1:0]       tmo_r, tmo_nxt;
   logic [arr_pkg::CNT_W-1:0]       wid_r, wid_nxt;
   logic [3:0]                      nbit_r, nbit_nxt;
   logic [arr_pkg::REPLY_BITS-1:0]  sh_r, sh_nxt;
   arr_pkg::arr_result_s            res_r, res_nxt;

   always_comb
   begin
      st_nxt   = st_r;
      tmo_nxt  = tmo_r;
      wid_nxt  = wid_r + 1'b1;
      nbit_nxt = nbit_r;
      sh_nxt   = sh_r;
      res_nxt  = res_r;
      res_nxt.done    = 1'b0;
      res_nxt.timeout = 1'b0;
      res_nxt.error   = 1'b0;
      if (st_r != RX_IDLE)
         tmo_nxt = tmo_r + 1'b1; // RQ17
      case (st_r)
         RX_IDLE:
            if (start)
            begin
               st_nxt  = RX_WAIT;
               tmo_nxt = '0;
            end
         RX_WAIT:
            if (!line_in)
            begin
               st_nxt   = RX_LOW;
               wid_nxt  = '0;
               nbit_nxt = '0;
            end
         RX_LOW:
            if (line_in)
            begin
               // long low pulse carries a one
               sh_nxt   = {sh_r[arr_pkg::REPLY_BITS-2:0], (wid_r >= CNT_W'(ONE_CYC))};
               nbit_nxt = nbit_r + 1'b1;
               wid_nxt  = '0;
               st_nxt   = RX_HIGH;
               if (nbit_r == 4'(arr_pkg::REPLY_BITS - 1))
               begin
                  st_nxt       = RX_IDLE;
                  res_nxt.done = 1'b1;
                  res_nxt.data = {sh_r[arr_pkg::REPLY_BITS-2:0],
                                  (wid_r >= CNT_W'(ONE_CYC))};
               end
            end
         RX_HIGH:
            if (!line_in)
            begin
               st_nxt  = RX_LOW;
               wid_nxt = '0;
            end
            else if (wid_r >= CNT_W'(GAP_CYC))
            begin
               // reply stalled mid-word
               st_nxt          = RX_IDLE;
               res_nxt.timeout = 1'b1; // RQ16
               res_nxt.error   = 1'b1; // RQ6
            end
         default:
            st_nxt = RX_IDLE;
      endcase
      // overall window; a started word that misses it is also an error
      if (st_r != RX_IDLE && st_nxt != RX_IDLE && tmo_r >= CNT_W'(TMO_CYC - 1))
      begin
         st_nxt          = RX_IDLE;
         res_nxt.timeout = 1'b1; // RQ2
         res_nxt.error   = (st_r != RX_WAIT); // RQ6
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_r   <= RX_IDLE;
         tmo_r  <= '0;
         wid_r  <= '0;
         nbit_r <= '0;
         sh_r   <= '0;
         res_r  <= '0;
      end
      else
      begin
         st_r   <= st_nxt;
         tmo_r  <= tmo_nxt;
         wid_r  <= wid_nxt;
         nbit_r <= nbit_nxt;
         sh_r   <= sh_nxt;
         res_r  <= res_nxt;
      end
   end

   assign res  = res_r;
   assign busy = (st_r != RX_IDLE);

endmodule : arr_reply_decoder

// ### arr_reply_asserts.sv
`timescale 1ns/1ns
module arr_reply_asserts
#(
   parameter int TMO_CYC = 30000,
   parameter int GAP_CYC = 400
)
(
   // clock and resets
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       reset_in_n,
   // host bus
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_oe,
   // transmit path
   input wire logic       tx_busy,
   input wire logic       tx_done,
   input wire logic       tx_line_level,
   input wire logic       sync_in,
   // antenna line and general pins
   input wire logic       antenna_line_pin_in,
   input wire logic       antenna_line_pin_out,
   input wire logic       antenna_line_pin_oe,
   input wire logic [7:0] gpio_in,
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] gpio_oe
);
   logic [2:0] age_r;
   logic [2:0] age_nxt;
   logic       up;

   // outputs lag the pin release by two sync flops, so wait before comparing
   always_comb
   begin
      age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
      if (sys_rst || !reset_in_n)
      begin
         age_nxt = 3'h0;
      end
      up = (age_r >= 3'h4) && reset_in_n;
   end

   always_ff @(posedge mclk)
   begin
      age_r <= age_nxt;
   end

   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_quiet;
      (gpio_oe == 8'h00 && !sda_oe && !antenna_line_pin_oe) [*2];
   endsequence

   chk_rst_quiet: assert property ($fell(sys_rst) |-> s_quiet)
      else $error("outputs driven right after reset");
   chk_pin_hold: assert property (!reset_in_n |=> s_quiet)
      else $error("outputs driven during pin reset");
   chk_pin_release: assert property ($rose(reset_in_n) |-> s_quiet)
      else $error("reset release not synchronised");
   chk_no_drive: assert property ((gpio_oe & 8'h5D) == 8'h00)
      else $error("input or reserved pin driven");
   chk_dir_follow: assert property (up |=> gpio_out[1] == $past(tx_busy))
      else $error("direction pin wrong");
   chk_line_out: assert property (up |=> antenna_line_pin_out == $past(tx_line_level))
      else $error("antenna line level wrong");
   chk_line_oe: assert property (up && antenna_line_pin_oe |-> $past(tx_busy))
      else $error("antenna line driven while receiving");
   chk_sync_out: assert property (up && gpio_oe[5] |-> gpio_out[5] == $past(sync_in))
      else $error("sync pin wrong");
   chk_sda_low: assert property (up && $changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data line changed while clock high");
endmodule : arr_reply_asserts

// ### arr_antenna_model.sv
`timescale 1ns/1ns
module arr_antenna_model
(
   // clock
   input wire logic mclk,
   // reply line, idle high through a pull-up
   output logic     line
);
   initial line = 1'b1;

   // a word cut short by nbits below ten is the only wrong answer offered
   task automatic reply(input int dly, input logic [9:0] val, input int nbits);
      repeat (dly) @(posedge mclk);
      for (int i = 9; i > 9 - nbits; i--)
      begin
         line <= 1'b0;
         repeat (val[i] ? 2600 : 200) @(posedge mclk);
         line <= 1'b1;
         repeat (200) @(posedge mclk);
      end
   endtask : reply
endmodule : arr_antenna_model

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int         TMO_CYC = 30000;
   localparam int         GAP_CYC = 400;
   localparam logic [6:0] DEV     = 7'h2A; // arbitrary
   typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} arr_tb_row_s;

   logic            mclk;
   logic            sys_rst;
   logic            reset_in_n;
   logic            scl;
   logic            sda_h;
   logic            tx_busy;
   logic            tx_done;
   logic            tx_line_level;
   logic            sync_in;
   logic            sda_oe;
   logic            ant_out;
   logic            ant_oe;
   logic            ant_line;
   logic [7:0]      gpio_out;
   logic [7:0]      gpio_oe;
   logic [7:0]      q;
   int              n;
   int              errors;
   int              checks;
   wire logic       sda_w  = sda_h & ~sda_oe;
   wire logic       ant_w  = ant_oe ? ant_out : ant_line;
   // undriven general pins 1 to 7 read low through pull-downs; pin 0 carries the antenna line
   wire logic [7:0] gpio_w = {gpio_oe[7:1] & gpio_out[7:1], ant_line};
   arr_tb_row_s     rows [8] = '{
      '{arr_pkg::OFS_GPIO_FUNC, 8'hA1, 8'hA1}, '{arr_pkg::OFS_LINK_CTRL, 8'h2D, 8'h05},
      '{arr_pkg::OFS_IRQ_MASK, 8'h28, 8'h28}, '{arr_pkg::OFS_REPLY_LO, 8'h55, 8'h00},
      '{arr_pkg::OFS_REPLY_HI, 8'hFF, 8'h00}, '{arr_pkg::OFS_IRQ_STATUS, 8'hFF, 8'h00},
      '{arr_pkg::OFS_IRQ_CLEAR, 8'hFF, 8'h00}, '{8'h80, 8'h5A, 8'h00}};

   arr_reply_receiver #(.DEV_ADDR(DEV), .TMO_CYC(TMO_CYC), .GAP_CYC(GAP_CYC)) u_arr_reply_receiver
   (
      .mclk(mclk), .sys_rst(sys_rst), .reset_in_n(reset_in_n),
      .scl_in(scl), .sda_in(sda_w), .sda_oe(sda_oe),
      .tx_busy(tx_busy), .tx_done(tx_done), .tx_line_level(tx_line_level), .sync_in(sync_in),
      .antenna_line_pin_in(ant_w), .antenna_line_pin_out(ant_out), .antenna_line_pin_oe(ant_oe),
      .gpio_in(gpio_w), .gpio_out(gpio_out), .gpio_oe(gpio_oe)
   );
   arr_antenna_model u_arr_antenna_model (.mclk(mclk), .line(ant_line));

   task automatic clk(input int c);
      repeat (c) @(posedge mclk);
   endtask : clk

   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8

   task automatic sbit(input logic b, output logic r);
      sda_h <= b;
      clk(4);
      scl <= 1'b1;
      clk(4);
      r = sda_w;
      scl <= 1'b0;
      clk(1);
   endtask : sbit

   // the acknowledge slot is always released; nack marks the last read byte
   task automatic xbyte(input logic [7:0] d, input logic nack, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--)
      begin
         sbit(d[i], r[i]);
      end
      sbit(1'b1, a);
      if (!nack)
      begin
         cmp8("ack", 8'h00, {7'h00, a});
      end
   endtask : xbyte

   task automatic i2c_start();
      sda_h <= 1'b1;
      clk(2);
      scl <= 1'b1;
      clk(4);
      sda_h <= 1'b0;
      clk(4);
      scl <= 1'b0;
      clk(2);
   endtask : i2c_start

   task automatic i2c_stop();
      sda_h <= 1'b0;
      clk(2);
      scl <= 1'b1;
      clk(4);
      sda_h <= 1'b1;
      clk(4);
   endtask : i2c_stop

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] w);
      logic [7:0] r;
      i2c_start();
      xbyte({DEV, 1'b0}, 1'b0, r);
      xbyte(a, 1'b0, r);
      xbyte(w, 1'b0, r);
      i2c_stop();
   endtask : reg_wr

   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      i2c_start();
      xbyte({DEV, 1'b0}, 1'b0, r);
      xbyte(a, 1'b0, r);
      i2c_start();
      xbyte({DEV, 1'b1}, 1'b0, r);
      xbyte(8'hFF, 1'b1, r);
      i2c_stop();
      cmp8("register", exp, r);
   endtask : reg_chk

   task automatic wait_irq(input int lim);
      n = 0;
      while (gpio_out[7] !== 1'b1 && n < lim)
      begin
         clk(1);
         n++;
      end
      if (n >= lim)
      begin
         errors++;
         $display("ERROR irq expected 1 seen 0");
         end_of_test();
      end
   endtask : wait_irq

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial
   begin
      clk(100000);
      errors++;
      $display("ERROR run expected end seen hang");
      end_of_test();
   end

   initial
   begin
      {sys_rst, reset_in_n, scl, sda_h} = 4'hB;
      {tx_busy, tx_done, tx_line_level, sync_in, errors, checks} = '0;
      clk(12);
      sys_rst <= 1'b0;
      clk(18);
      reset_in_n <= 1'b1;
      clk(10);
      cmp8("gpio_oe", 8'h00, gpio_oe);
      foreach (rows[i])
      begin
         reg_chk(rows[i].a, 8'h00);
      end
      foreach (rows[i])
      begin
         reg_wr(rows[i].a, rows[i].w);
         reg_chk(rows[i].a, rows[i].e);
      end
      cmp8("gpio_oe", 8'hA2, gpio_oe);
      {sync_in, tx_busy, tx_line_level} <= 3'h7;
      clk(3);
      cmp8("pins", 8'h0F, {3'h0, gpio_out[7], gpio_out[5], gpio_out[1], ant_oe, ant_out});
      {tx_busy, tx_line_level} <= 2'h0;
      clk(3);
      cmp8("direction", 8'h00, {6'h00, gpio_out[1], ant_oe});
      reg_wr(arr_pkg::OFS_LINK_CTRL, 8'h10);
      u_arr_antenna_model.reply(3000, 10'h2C5, 10);
      wait_irq(50);
      reg_chk(arr_pkg::OFS_IRQ_STATUS, 8'h20);
      reg_chk(arr_pkg::OFS_REPLY_LO, 8'hC5);
      reg_chk(arr_pkg::OFS_REPLY_HI, 8'h02);
      reg_chk(arr_pkg::OFS_LINK_CTRL, 8'h10);
      reg_wr(arr_pkg::OFS_IRQ_CLEAR, 8'h20);
      clk(3);
      cmp8("irq", 8'h00, {7'h00, gpio_out[7]});
      reg_wr(arr_pkg::OFS_LINK_CTRL, 8'h14);
      tx_done <= 1'b1;
      clk(1);
      tx_done <= 1'b0;
      wait_irq(TMO_CYC + 40);
      cmp8("timeout", 8'h01, {7'h00, n >= TMO_CYC - 2 && n <= TMO_CYC + 8});
      reg_chk(arr_pkg::OFS_IRQ_STATUS, 8'h18);
      reg_chk(arr_pkg::OFS_LINK_CTRL, 8'h14);
      reg_chk(arr_pkg::OFS_REPLY_LO, 8'h00);
      reg_wr(arr_pkg::OFS_IRQ_CLEAR, 8'h18);
      reg_wr(arr_pkg::OFS_LINK_CTRL, 8'h10);
      u_arr_antenna_model.reply(100, 10'h3FF, 3);
      wait_irq(GAP_CYC + 100);
      reg_chk(arr_pkg::OFS_IRQ_STATUS, 8'h08);
      reg_chk(arr_pkg::OFS_LINK_CTRL, 8'h30);
      reg_wr(arr_pkg::OFS_IRQ_CLEAR, 8'h08);
      reg_wr(arr_pkg::OFS_LINK_CTRL, 8'h11);
      u_arr_antenna_model.reply(100, 10'h001, 10);
      cmp8("one-pin direction", 8'h02, {6'h00, gpio_oe[1], gpio_out[1]});
      wait_irq(50);
      reg_chk(arr_pkg::OFS_REPLY_LO, 8'h01);
      reg_chk(arr_pkg::OFS_LINK_CTRL, 8'h11);
      reset_in_n <= 1'b0;
      clk(30);
      reset_in_n <= 1'b1;
      clk(4);
      cmp8("gpio_oe", 8'h00, gpio_oe);
      reg_chk(arr_pkg::OFS_GPIO_FUNC, 8'h00);
      end_of_test();
   end
endmodule : testbench

bind arr_reply_receiver arr_reply_asserts #(.TMO_CYC(TMO_CYC), .GAP_CYC(GAP_CYC)) u_arr_reply_asserts
(
   .mclk(mclk), .sys_rst(sys_rst), .reset_in_n(reset_in_n),
   .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
   .tx_busy(tx_busy), .tx_done(tx_done), .tx_line_level(tx_line_level), .sync_in(sync_in),
   .antenna_line_pin_in(antenna_line_pin_in), .antenna_line_pin_out(antenna_line_pin_out),
   .antenna_line_pin_oe(antenna_line_pin_oe),
   .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe)
);
